// [src/sptc_top.sv]
/*
   Transmit control and status part of an addressable serial port:
   Wishbone register slave, pin hand-over, async and sync transmitter.
   Assumes a classic Wishbone master on MCLK and pin inputs that are
   already synchronous to MCLK.
*/
// How it works
// - Pins go to the port only with port enable and direction bits 7:6 set
// - Async full duplex, sync master, sync slave; mode bit one selects sync
// - A ninth bit may mark address words for multiprocessor address detection
// - Transmit control register is eight bits wide at address 98h
// - Sync: clock source bit one is master from baud generator, zero is slave
// - Async: high-speed select picks fast rate; ignored in sync mode
// - Read-only shift empty bit resets to one, zero while shifting
`timescale 1ns/1ns
`include "sptc_cfg.svh"
module sptc_top
   import sptc_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic       WB_CYC_I,
   input  wire logic       WB_STB_I,
   input  wire logic       WB_WE_I,
   input  wire logic [7:0] WB_ADR_I,
   input  wire logic [3:0] WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]     WB_DAT_O,
   output logic            WB_ACK_O,
   input  wire logic       TX_CLOCK_PIN_IN,
   output logic            TX_CLOCK_PIN_OUT,
   output logic            TX_CLOCK_PIN_OE,
   input  wire logic       RX_DATA_PIN_IN,
   output logic            RX_DATA_PIN_OUT,
   output logic            RX_DATA_PIN_OE,
   output logic            PORT_ROUTED,
   output logic            RX_NINE_BIT,
   output logic            RX_SINGLE_ENABLE,
   output logic            RX_CONT_ENABLE,
   output logic            RX_ADDRESS_DETECT
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic           clock_source_select;
   logic           ninth_bit_tx_select;
   logic           transmit_enable_bit;
   logic           sync_mode;
   logic           high_speed_baud_select;
   logic           shift_register_empty;
   logic           ninth_tx_data_bit;
   logic           serial_port_enable;
   logic           rx_nine;
   logic           single_receive_enable;
   logic           continuous_receive_enable;
   logic           address_detect_enable;
   logic [7:0]     port_c_direction;
   logic [7:0]     baud_reload;
   logic [7:0]     hold_data;
   logic           hold_full;

   // ----------------------------------------------------------------
   // Transmitter state
   // ----------------------------------------------------------------
   sptc_state_type state;
   sptc_state_type next_state;
   logic [8:0]     transmit_shift_register;
   logic [8:0]     next_shift;
   logic [3:0]     bit_cnt;
   logic [3:0]     next_bit_cnt;
   logic [5:0]     sub_cnt;
   logic [5:0]     next_sub_cnt;
   logic           line;
   logic           next_line;
   logic           clk_out;
   logic           next_clk_out;
   logic           ck_prev;
   logic           baud_tick;

   // Reset images as named constants, so that single fields can be
   // picked out of them; a bare literal cannot be indexed
   localparam logic [7:0] txcs_init = `SPTC_TXCS_RESET;
   localparam logic [7:0] rxcs_init = `SPTC_RXCS_RESET;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire wb_req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wb_wr     = wb_req & WB_WE_I & WB_SEL_I[0];
   wire hit_txcs  = (WB_ADR_I == `SPTC_OFF_TXCS);
   wire hit_rxcs  = (WB_ADR_I == `SPTC_OFF_RXCS);
   wire hit_txd   = (WB_ADR_I == `SPTC_OFF_TXDATA);
   wire hit_baud  = (WB_ADR_I == `SPTC_OFF_BAUD);
   wire hit_dir   = (WB_ADR_I == `SPTC_OFF_PORTDIR);
   wire wr_txcs   = wb_wr & hit_txcs;
   wire wr_rxcs   = wb_wr & hit_rxcs;
   wire wr_txd    = wb_wr & hit_txd;
   wire wr_baud   = wb_wr & hit_baud;
   wire wr_dir    = wb_wr & hit_dir;

   // Bit 3 fixed at zero, shift_register_empty is the live shifter status
   wire [7:0] txcs_view = {clock_source_select, ninth_bit_tx_select,
                           transmit_enable_bit, sync_mode, 1'b0,
                           high_speed_baud_select, shift_register_empty,
                           ninth_tx_data_bit};
   wire [7:0] rxcs_view = {serial_port_enable, rx_nine,
                           single_receive_enable, continuous_receive_enable,
                           address_detect_enable, 3'h0};
   wire [7:0] rd_byte   = hit_txcs ? txcs_view :
                          hit_rxcs ? rxcs_view :
                          hit_txd  ? {7'h00, ~hold_full} :
                          hit_baud ? baud_reload :
                          hit_dir  ? port_c_direction : 8'h00;

   // ----------------------------------------------------------------
   // Mode and enable decode
   // ----------------------------------------------------------------
   // Both direction bits must be set as well as the port enable
   wire routed    = serial_port_enable & (&port_c_direction[7:6]);
   wire rx_any    = single_receive_enable | continuous_receive_enable;
   wire tx_on     = routed & transmit_enable_bit
                    & ~(sync_mode & rx_any);
   wire is_master = sync_mode & clock_source_select;
   wire is_slave  = sync_mode & ~clock_source_select;
   // Speed select only matters in async mode
   wire [5:0] ticks_last = sync_mode ? `SPTC_TICKS_SYNC :
                           high_speed_baud_select ? `SPTC_TICKS_HIGH :
                           `SPTC_TICKS_LOW;
   wire ck_fall   = ck_prev & ~TX_CLOCK_PIN_IN;
   // Slave advances on the partner's falling clock edge
   wire step      = is_slave ? ck_fall : baud_tick;
   wire sub_last  = is_slave | (sub_cnt == ticks_last);
   wire bit_done  = step & sub_last;
   wire [3:0] last_bit = ninth_bit_tx_select ? 4'h8 : 4'h7;
   wire move      = tx_on & hold_full & (state == ST_IDLE);

   // ----------------------------------------------------------------
   // Baud generator
   // ----------------------------------------------------------------
   sptc_baud u_baud (
      .MCLK   (MCLK),
      .RST    (RST),
      .run    (tx_on & ~is_slave),
      .reload (baud_reload),
      .tick   (baud_tick)
   );

   // ----------------------------------------------------------------
   // Wishbone answer
   // ----------------------------------------------------------------
   // One wait state; ack falls the cycle after it rose
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end
      else
      begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= {24'h00_0000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // Transmit control register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         clock_source_select    <= txcs_init[`SPTC_TX_CLOCK_SOURCE_SELECT];
         ninth_bit_tx_select    <= txcs_init[`SPTC_TX_NINE];
         transmit_enable_bit    <= txcs_init[`SPTC_TX_EN];
         sync_mode              <= txcs_init[`SPTC_TX_SYNC];
         high_speed_baud_select <= txcs_init[`SPTC_TX_HIGH_SPEED_BAUD_SELECT];
         ninth_tx_data_bit      <= txcs_init[`SPTC_TX_D9];
      end
      else if (wr_txcs)
      begin
         clock_source_select    <= WB_DAT_I[`SPTC_TX_CLOCK_SOURCE_SELECT];
         ninth_bit_tx_select    <= WB_DAT_I[`SPTC_TX_NINE];
         transmit_enable_bit    <= WB_DAT_I[`SPTC_TX_EN];
         sync_mode              <= WB_DAT_I[`SPTC_TX_SYNC];
         high_speed_baud_select <= WB_DAT_I[`SPTC_TX_HIGH_SPEED_BAUD_SELECT];
         ninth_tx_data_bit      <= WB_DAT_I[`SPTC_TX_D9];
      end
   end

   // ----------------------------------------------------------------
   // Receive control, baud reload and port direction
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         serial_port_enable        <= rxcs_init[`SPTC_RX_SERIAL_PORT_ENABLE];
         rx_nine                   <= rxcs_init[`SPTC_RX_NINE];
         single_receive_enable     <= rxcs_init[`SPTC_RX_SINGLE_RECEIVE_ENABLE];
         continuous_receive_enable <= rxcs_init[`SPTC_RX_CONTINUOUS_RECEIVE_ENABLE];
         address_detect_enable     <= rxcs_init[`SPTC_RX_ADDEN];
      end
      else if (wr_rxcs)
      begin
         serial_port_enable        <= WB_DAT_I[`SPTC_RX_SERIAL_PORT_ENABLE];
         rx_nine                   <= WB_DAT_I[`SPTC_RX_NINE];
         single_receive_enable     <= WB_DAT_I[`SPTC_RX_SINGLE_RECEIVE_ENABLE];
         continuous_receive_enable <= WB_DAT_I[`SPTC_RX_CONTINUOUS_RECEIVE_ENABLE];
         address_detect_enable     <= WB_DAT_I[`SPTC_RX_ADDEN];
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         baud_reload      <= `SPTC_BAUD_RESET;
         port_c_direction <= `SPTC_DIR_RESET;
      end
      else
      begin
         if (wr_baud)
            baud_reload <= WB_DAT_I[7:0];
         if (wr_dir)
            port_c_direction <= WB_DAT_I[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Transmit holding byte
   // ----------------------------------------------------------------
   // A write in the same cycle as a move keeps the flag set
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         hold_data <= 8'h00;
         hold_full <= 1'b0;
      end
      else if (wr_txd)
      begin
         hold_data <= WB_DAT_I[7:0];
         hold_full <= 1'b1;
      end
      else if (move)
         hold_full <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Transmitter sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state   = state;
      next_shift   = transmit_shift_register;
      next_bit_cnt = bit_cnt;
      next_sub_cnt = sub_cnt;
      next_line    = line;
      case (state)
         ST_IDLE:
         begin
            next_line = 1'b1;
            if (move)
            begin
               // Ninth bit rides along as address mark or parity
               next_shift   = {ninth_tx_data_bit, hold_data};
               next_bit_cnt = 4'h0;
               next_sub_cnt = 6'h00;
               if (sync_mode)
               begin
                  next_state = ST_DATA;
                  next_line  = hold_data[0];
               end
               else
               begin
                  next_state = ST_START;
                  next_line  = 1'b0;
               end
            end
         end
         ST_START, ST_STOP:
         begin
            if (bit_done)
            begin
               next_sub_cnt = 6'h00;
               next_state   = (state == ST_START) ? ST_DATA : ST_IDLE;
               next_line    = (state == ST_START) ? transmit_shift_register[0] : 1'b1;
            end
            else if (step)
               next_sub_cnt = sub_cnt + 6'h01;
         end
         default:
         begin
            if (bit_done)
            begin
               next_sub_cnt = 6'h00;
               next_shift   = {1'b0, transmit_shift_register[8:1]};
               if (bit_cnt == last_bit)
               begin
                  next_state = sync_mode ? ST_IDLE : ST_STOP;
                  next_line  = 1'b1;
               end
               else
               begin
                  next_bit_cnt = bit_cnt + 4'h1;
                  next_line    = transmit_shift_register[1];
               end
            end
            else if (step)
               next_sub_cnt = sub_cnt + 6'h01;
         end
      endcase
      // Dropping enable abandons the frame at once
      if (!tx_on)
      begin
         next_state   = ST_IDLE;
         next_line    = 1'b1;
         next_sub_cnt = 6'h00;
      end
      // Master clock low in first half of a bit, high in second
      next_clk_out = is_master & (next_state == ST_DATA)
                     & (next_sub_cnt >= `SPTC_SYNC_HALF);
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         state                   <= ST_IDLE;
         transmit_shift_register <= 9'h000;
         bit_cnt                 <= 4'h0;
         sub_cnt                 <= 6'h00;
         line                    <= 1'b1;
         clk_out                 <= 1'b0;
         ck_prev                 <= 1'b0;
         shift_register_empty    <= txcs_init[`SPTC_TX_SHIFT_REGISTER_EMPTY];
      end
      else
      begin
         state                   <= next_state;
         transmit_shift_register <= next_shift;
         bit_cnt                 <= next_bit_cnt;
         sub_cnt                 <= next_sub_cnt;
         line                    <= next_line;
         clk_out                 <= next_clk_out;
         ck_prev                 <= TX_CLOCK_PIN_IN;
         shift_register_empty    <= (next_state == ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Pin hand-over
   // ----------------------------------------------------------------
   // Unrouted pins are released so the port logic owns them
   assign PORT_ROUTED       = routed;
   assign TX_CLOCK_PIN_OUT  = sync_mode ? clk_out : line;
   assign TX_CLOCK_PIN_OE   = routed & (~sync_mode | is_master);
   assign RX_DATA_PIN_OUT   = line;
   assign RX_DATA_PIN_OE    = routed & sync_mode & (state != ST_IDLE);
   assign RX_NINE_BIT       = rx_nine;
   assign RX_SINGLE_ENABLE  = single_receive_enable;
   assign RX_CONT_ENABLE    = continuous_receive_enable;
   assign RX_ADDRESS_DETECT = address_detect_enable;

endmodule // sptc_top

// [src/sptc_cfg.svh]
/*
   Offsets, field positions, reset values and timing counts for the
   serial port transmit control block. Definitions only; included by
   the block's design files.
*/
`ifndef SPTC_CFG_SVH
`define SPTC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPTC_OFF_TXCS     8'h98
`define SPTC_OFF_RXCS     8'hA0
`define SPTC_OFF_TXDATA   8'hA4
`define SPTC_OFF_BAUD     8'hA8
`define SPTC_OFF_PORTDIR  8'hAC

// ----------------------------------------------------------------
// Field positions, transmit control register
// ----------------------------------------------------------------
`define SPTC_TX_CLOCK_SOURCE_SELECT      7
`define SPTC_TX_NINE      6
`define SPTC_TX_EN        5
`define SPTC_TX_SYNC      4
`define SPTC_TX_HIGH_SPEED_BAUD_SELECT      2
`define SPTC_TX_SHIFT_REGISTER_EMPTY      1
`define SPTC_TX_D9        0

// ----------------------------------------------------------------
// Field positions, receive control register
// ----------------------------------------------------------------
`define SPTC_RX_SERIAL_PORT_ENABLE      7
`define SPTC_RX_NINE      6
`define SPTC_RX_SINGLE_RECEIVE_ENABLE      5
`define SPTC_RX_CONTINUOUS_RECEIVE_ENABLE      4
`define SPTC_RX_ADDEN     3

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define SPTC_TXCS_RESET   8'h02
`define SPTC_RXCS_RESET   8'h00
`define SPTC_BAUD_RESET   8'h00
`define SPTC_DIR_RESET    8'hFF
`define SPTC_TICKS_HIGH   6'h0F
`define SPTC_TICKS_LOW    6'h3F
`define SPTC_TICKS_SYNC   6'h03
`define SPTC_SYNC_HALF    6'h02

`endif

// [src/sptc_pkg.sv]
/*
   Types shared by the serial port transmit control block.
   Assumes nothing of its surroundings.
*/
package sptc_pkg;

   // Transmitter sequencing
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } sptc_state_type;

endpackage

// [src/sptc_baud.sv]
/*
   Baud rate generator: a reloading down counter that emits one tick
   each time it reaches zero. Assumes a single clock and the reload
   value held stable by the caller.
*/
`timescale 1ns/1ns
module sptc_baud
   import sptc_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic       run,
   input  wire logic [7:0] reload,
   output logic            tick
);

   logic [7:0] count;

   // ----------------------------------------------------------------
   // Down counter
   // ----------------------------------------------------------------
   // Stopped counter restarts from the reload value, so the first
   // tick after enabling is a full period away
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         count <= 8'h00;
         tick  <= 1'b0;
      end
      else if (!run)
      begin
         count <= reload;
         tick  <= 1'b0;
      end
      else
      begin
         tick  <= (count == 8'h00);
         count <= (count == 8'h00) ? reload : count - 8'h01;
      end
   end

endmodule // sptc_baud

// [dv/sptc_checker.sv]
/*
   Concurrent checks for the serial port transmit control block.
   Assumes it is bound to sptc_top and sees only its ports.
*/
`timescale 1ns/1ns
module sptc_checker
(
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        TX_CLOCK_PIN_OE,
   input wire logic        RX_DATA_PIN_OE,
   input wire logic        PORT_ROUTED,
   input wire logic        RX_NINE_BIT,
   input wire logic        RX_SINGLE_ENABLE,
   input wire logic        RX_CONT_ENABLE,
   input wire logic        RX_ADDRESS_DETECT
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // Request, read answer and mapped offsets
   wire req    = WB_CYC_I && WB_STB_I;
   wire rd_ack = WB_ACK_O && !WB_WE_I;
   wire mapped = WB_ADR_I inside {8'h98, 8'hA0, 8'hA4, 8'hA8, 8'hAC};

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   AST_ACK_ONE: assert property (req && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   AST_ACK_IDLE: assert property (!req |=> !WB_ACK_O)
      else $error("ack without request");
   AST_TXCS_BIT3: assert property (rd_ack && WB_ADR_I == 8'h98 |->
      WB_DAT_O[3] == 1'b0 && WB_DAT_O[31:8] == 24'h000000)
      else $error("bad unused bits in control read");
   AST_UNMAPPED: assert property (rd_ack && !mapped |-> WB_DAT_O == 32'h00000000)
      else $error("unmapped read not zero");
   AST_ROUTE_OE: assert property (TX_CLOCK_PIN_OE || RX_DATA_PIN_OE |-> PORT_ROUTED)
      else $error("pin driven while not routed");
   AST_ROUTE_RISE: assert property ($rose(PORT_ROUTED) |-> WB_ACK_O && WB_WE_I)
      else $error("routing changed without a write");
   AST_RX_WRITE: assert property ($changed(RX_NINE_BIT) || $changed(RX_ADDRESS_DETECT)
      |-> WB_ACK_O && WB_WE_I && WB_ADR_I == 8'hA0)
      else $error("receive bits changed without a write");
   AST_SYNC_RX_WINS: assert property ((RX_SINGLE_ENABLE || RX_CONT_ENABLE)
      && RX_DATA_PIN_OE |-> ##[0:2] !RX_DATA_PIN_OE)
      else $error("transmit kept running over receive enable");
endmodule // sptc_checker

bind sptc_top sptc_checker u_sptc_checker (.MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .TX_CLOCK_PIN_OE(TX_CLOCK_PIN_OE), .RX_DATA_PIN_OE(RX_DATA_PIN_OE),
   .PORT_ROUTED(PORT_ROUTED), .RX_NINE_BIT(RX_NINE_BIT), .RX_SINGLE_ENABLE(RX_SINGLE_ENABLE),
   .RX_CONT_ENABLE(RX_CONT_ENABLE), .RX_ADDRESS_DETECT(RX_ADDRESS_DETECT));

// [dv/sptc_far_end.sv]
/*
   Far end of the serial line: a terminal receiving async frames.
   Assumes the bench calls get_frame with the bit length in clocks.
*/
`timescale 1ns/1ns
module sptc_far_end
(
   input  wire logic MCLK,
   input  wire logic line,
   output logic      slave_clk,
   output logic      data_in
);
   // ------------------------------------------------------------
   // Idle pins
   // ------------------------------------------------------------
   // Slave clock stands still outside frames; the unused data line
   // toggles so a stale level is never read as a driven one
   initial slave_clk = 1'b1;
   initial data_in = 1'b0;
   always @(posedge MCLK) data_in <= ~data_in;

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   // Samples mid-bit on the falling edge, clear of register updates
   task automatic get_frame(input int bl, input int nb, output logic [8:0] v,
                            output logic ok);
      int i;
      v = 9'h000;
      @(negedge MCLK iff line === 1'b0);
      repeat (bl / 2) @(negedge MCLK);
      ok = (line === 1'b0);
      for (i = 0; i < nb; i++)
      begin
         repeat (bl) @(negedge MCLK);
         v[i] = line;
      end
      repeat (bl) @(negedge MCLK);
      ok = ok && (line === 1'b1);
   endtask

   // One slave clock bit: falls on a rising edge, low two clocks and
   // high two more, so the block sees exactly one falling edge
   task automatic clock_bit();
      @(posedge MCLK);
      slave_clk <= 1'b0;
      repeat (2) @(posedge MCLK);
      slave_clk <= 1'b1;
      repeat (2) @(posedge MCLK);
   endtask
endmodule // sptc_far_end

// [dv/tb.sv]
/*
   Self-checking bench for sptc_top: registers over classic Wishbone,
   pin hand-over, async frames and the sync receive override.
   Assumes the checker is bound and the far end model sits on the pins.
*/
`timescale 1ns/1ns
module tb;
   logic        MCLK, RST, cyc, stb, we, ok, h, n9;
   logic [7:0]  adr, q, v, r;
   logic [3:0]  sel;
   logic [31:0] dat_i;
   logic [8:0]  f, v9;
   wire  [31:0] dat_o;
   wire         ack, tx_out, tx_oe, rx_out, rx_oe, routed, rx9, rxs, rxc, rxa, sclk, din;
   int          miscompares, check_count, i, n;
   int          seed = 32'hfbb5baf2;

   sptc_top u_sptc_top (.MCLK(MCLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .TX_CLOCK_PIN_IN(sclk), .TX_CLOCK_PIN_OUT(tx_out),
      .TX_CLOCK_PIN_OE(tx_oe), .RX_DATA_PIN_IN(din), .RX_DATA_PIN_OUT(rx_out),
      .RX_DATA_PIN_OE(rx_oe), .PORT_ROUTED(routed), .RX_NINE_BIT(rx9),
      .RX_SINGLE_ENABLE(rxs), .RX_CONT_ENABLE(rxc), .RX_ADDRESS_DETECT(rxa));
   // Released line floats to its pull-up level
   sptc_far_end u_sptc_far_end (.MCLK(MCLK), .line(tx_oe ? tx_out : 1'b1), .slave_clk(sclk),
      .data_in(din));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic int bit_clocks(input logic [7:0] rl, input logic hs);
      return (int'(rl) + 1) * (hs ? 16 : 64);
   endfunction
   // Bit 3 unused, bit 1 read-only and empty while idle
   function automatic logic [7:0] txcs_exp(input logic [7:0] w);
      return (w & 8'hF5) | 8'h02;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; request held until ack is seen at a falling edge, then dropped at the next rising edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] rd);
      int k;
      k = 0;
      @(posedge MCLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_i <= {24'h000000, d};
      while (ack !== 1'b1 && k < 100)
      begin
         @(negedge MCLK);
         k++;
      end
      if (k >= 100)
         miscompares++;
      @(posedge MCLK);
      rd = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d, 4'hF, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      wb(a, 1'b0, 8'h00, 4'hF, q);
      chk(q, exp);
   endtask
   task conclude;
      if (miscompares == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial
   begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end
   // Whole sequence needs about 1300 cycles; this bounds a hang
   initial
   begin
      repeat (20000) @(posedge MCLK);
      miscompares++;
      conclude;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {RST, cyc, stb, we, adr, sel, dat_i} = {1'b1, 3'b000, 8'h00, 4'h0, 32'h0};
      miscompares = 0;
      check_count = 0;
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      rdc(8'h98, 8'h02);
      rdc(8'hAC, 8'hFF);
      rdc(8'h10, 8'h00);
      chk(routed, 1'b0);
      // Random control writes, then a write with the byte lane off
      for (i = 0; i < 4; i++)
      begin
         v = $random(seed) | 8'h08;
         wr(8'h98, v);
         rdc(8'h98, txcs_exp(v));
      end
      wb(8'h98, 1'b1, 8'hFF, 4'h0, q);
      rdc(8'h98, txcs_exp(v));
      // Every enable and direction combination
      for (i = 0; i < 8; i++)
      begin
         v = ($random(seed) & 8'h78) | {i[2], 7'h00};
         wr(8'hA0, v);
         wr(8'hAC, {i[1:0], 6'h3F});
         chk(routed, i[2] & i[1] & i[0]);
         chk(rx9, v[6]);
         chk(rxa, v[3]);
         chk(rxs, v[5]);
         chk(rxc, v[4]);
      end
      // Async frames: fast 8-bit, then slow 9-bit
      wr(8'hA0, 8'h80);
      for (i = 0; i < 2; i++)
      begin
         h = ~i[0];
         n9 = i[0];
         r = {7'h00, ~i[0]};
         v9 = $random(seed);
         v = {1'b0, n9, 1'b1, 2'b00, h, 1'b0, v9[8]};
         wr(8'hA8, r);
         wr(8'h98, v);
         fork
            u_sptc_far_end.get_frame(bit_clocks(r, h), n9 ? 9 : 8, f, ok);
            begin
               wr(8'hA4, v9[7:0]);
               rdc(8'h98, v);
            end
         join
         chk(f, n9 ? v9 : {1'b0, v9[7:0]});
         chk(ok, 1'b1);
         chk({tx_oe, rx_oe}, 2'b10);
         repeat (bit_clocks(r, h)) @(posedge MCLK);
         rdc(8'h98, v | 8'h02);
      end
      // Sync master, then receive override, then slave
      wr(8'hA8, 8'h00);
      wr(8'h98, 8'hB0);
      chk(tx_oe, 1'b1);
      r = $random(seed);
      wr(8'hA4, r);
      n = 0;
      while (rx_oe !== 1'b1 && n < 50)
      begin
         @(negedge MCLK);
         n++;
      end
      chk(rx_oe, 1'b1);
      // Master frame as a receiver sees it: data taken on each rising clock
      for (n = 0; n < 8; n++)
      begin
         @(posedge tx_out);
         f[n] = rx_out;
      end
      chk(f[7:0], r);
      // Second frame is cut by the receive enable while it runs
      wr(8'hA4, ~r);
      wr(8'hA0, 8'h90);
      @(negedge MCLK);
      chk(rx_oe, 1'b0);
      wr(8'hA0, 8'h80);
      wr(8'h98, 8'h30);
      chk(tx_oe, 1'b0);
      // Slave: the far end clocks each bit out with one falling edge
      r = $random(seed);
      wr(8'hA4, r);
      for (n = 0; n < 8; n++)
      begin
         @(negedge MCLK);
         f[n] = rx_out;
         u_sptc_far_end.clock_bit();
      end
      chk(f[7:0], r);
      conclude;
   end
endmodule // tb
